/* core/eec_ctrl.sv */
`timescale 1ns/100ps
module eec_ctrl
   import eec_pkg::*;
#(
   parameter int ERASE_CYCLES = EEC_ERASE_CYC,
   parameter int PROG_CYCLES = EEC_PROG_CYC
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic stop_mode_enter,
   input wire logic can_sleep_enter,
   input wire logic can_wake,
   input wire logic wired_or_mask_option,
   input wire logic upper_region_protect,
   output logic pump_enable_out,
   output logic wired_or_irq_enable,
   output logic bus_clock_output_select,
   output logic nvm_busy,
   output logic nvm_done
);
   // ************************************************************
   // state
   // ************************************************************
   logic wired_or_irq_enable_q, wired_or_irq_enable_d;
   logic caf_q, caf_d;
   logic bus_clock_output_select_q, bus_clock_output_select_d;
   logic era_q, era_d;
   logic lat_q, lat_d;
   logic pgm_q, pgm_d;
   logic cap_q, cap_d;
   logic [7:0] tgt_addr_q, tgt_addr_d;
   logic [7:0] tgt_data_q, tgt_data_d;
   logic done_q, done_d;
   logic refused_q, refused_d;
   logic [7:0] rdata_q, rdata_d;

   logic is_ctrl, is_stat, is_arr;
   logic wr_ctrl, wr_arr;
   logic cap_ok, prot_hit;
   logic arr_we;
   logic [7:0] arr_wdata;
   logic [7:0] arr_rdata;
   logic [EEC_ARR_AW-1:0] arr_raddr;
   logic tmr_done, tmr_pulse;
   logic [EEC_TMR_W-1:0] tmr_len;
   eec_mode_t mode;

   // ************************************************************
   // address decode
   // ************************************************************
   assign is_ctrl = (bus_addr == EEC_CTRL_ADDR);
   assign is_stat = (bus_addr == EEC_STAT_ADDR);
   // 256 bytes at the array base [RULE1]
   assign is_arr = (bus_addr[15:EEC_ARR_AW] == EEC_ARR_BASE[15:EEC_ARR_AW]);
   assign wr_ctrl = bus_wr && is_ctrl;
   assign wr_arr = bus_wr && is_arr;

   // ************************************************************
   // mode decode of erase, latch and pump bits
   // ************************************************************
   always_comb begin
      case ({era_q, lat_q, pgm_q}) // [RULE3]
         3'b010: mode = EEC_MODE_LOAD;
         3'b011: mode = EEC_MODE_PROG;
         3'b110: mode = EEC_MODE_ERA_RDY;
         3'b111: mode = EEC_MODE_ERASING;
         default: mode = EEC_MODE_READ;
      endcase
   end

   // ************************************************************
   // capture and protection checks
   // ************************************************************
   // only one address per sequence, none once the pump runs
   assign cap_ok = lat_q && !pgm_q &&
      (!cap_q || (bus_addr[EEC_ARR_AW-1:0] == tgt_addr_q)); // [RULE15] [RULE14]
   // the low 32 bytes never fail, upper ones need the protect bit
   assign prot_hit = (tgt_addr_q > EEC_UNPROT_TOP) && !upper_region_protect; // [RULE17] [RULE18]

   // ************************************************************
   // wait timer: length chosen by the operation
   // ************************************************************
   assign tmr_len = era_q ? EEC_TMR_W'(ERASE_CYCLES) : EEC_TMR_W'(PROG_CYCLES);

   eec_wait_timer u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(pgm_q),
      .len(tmr_len),
      .done(tmr_done),
      .done_pulse(tmr_pulse)
   );

   // ************************************************************
   // array write at the end of the wait
   // ************************************************************
   // erase gives all ones, program only clears bits, erase data unused
   assign arr_wdata = era_q ? EEC_ERASED : (arr_rdata & tgt_data_q); // [RULE12]
   assign arr_we = tmr_pulse && !prot_hit; // [RULE18]
   // during an operation the read port serves the target byte
   assign arr_raddr = pgm_q ? tgt_addr_q : bus_addr[EEC_ARR_AW-1:0];

   eec_array u_array (
      .sys_clk(sys_clk),
      .rd_addr(arr_raddr),
      .rd_data(arr_rdata),
      .wr_en(arr_we),
      .wr_addr(tgt_addr_q),
      .wr_data(arr_wdata)
   );

   // ************************************************************
   // control register next values
   // ************************************************************
   always_comb begin
      wired_or_irq_enable_d = wired_or_irq_enable_q;
      caf_d = caf_q;
      bus_clock_output_select_d = bus_clock_output_select_q;
      era_d = era_q;
      lat_d = lat_q;
      pgm_d = pgm_q;
      cap_d = cap_q;
      tgt_addr_d = tgt_addr_q;
      tgt_data_d = tgt_data_q;
      if (wr_ctrl) begin
         wired_or_irq_enable_d = bus_wdata[EEC_CB_WIRED_OR_IRQ_ENABLE];
         bus_clock_output_select_d = bus_wdata[EEC_CB_BUS_CLOCK_OUTPUT_SELECT];
         lat_d = bus_wdata[EEC_CB_LAT];
         // select may only change before an address is taken
         if (!cap_q) begin
            era_d = bus_wdata[EEC_CB_ERA]; // [RULE6]
         end
         // pump needs captured data; writing zero cannot stop it
         if (bus_wdata[EEC_CB_PGM] && cap_q && lat_q) begin
            pgm_d = 1'b1; // [RULE9]
         end
      end
      // address and data taken while latch set and pump off
      if (wr_arr && cap_ok) begin
         cap_d = 1'b1; // [RULE7]
         tgt_addr_d = bus_addr[EEC_ARR_AW-1:0];
         tgt_data_d = bus_wdata;
      end
      // stop entry drops back to read mode and stops the pump
      if (stop_mode_enter) begin
         lat_d = 1'b0; // [RULE8] [RULE19]
      end
      // latch low forces select and pump low
      if (!lat_d) begin
         era_d = 1'b0; // [RULE7]
         pgm_d = 1'b0; // [RULE9]
         cap_d = 1'b0;
      end
      // interrupt enable exists only with the mask option
      wired_or_irq_enable_d = wired_or_irq_enable_d & wired_or_mask_option; // [RULE4]
      // sleep flag follows the can module, set wins over wake
      if (can_wake) begin
         caf_d = 1'b0; // [RULE5]
      end
      if (can_sleep_enter) begin
         caf_d = 1'b1; // [RULE5]
      end
   end

   // ************************************************************
   // status next values: done and refused stick until latch clears
   // ************************************************************
   always_comb begin
      done_d = done_q;
      refused_d = refused_q;
      if (!lat_d) begin
         done_d = 1'b0;
         refused_d = 1'b0;
      end
      if (tmr_pulse) begin
         done_d = 1'b1; // [RULE21]
         refused_d = prot_hit; // [RULE18]
      end
   end

   // ************************************************************
   // read data, one cycle after the strobe
   // ************************************************************
   always_comb begin
      rdata_d = EEC_ZERO;
      if (bus_rd) begin
         if (is_ctrl) begin
            // bits 5 and 4 always zero [RULE20]
            rdata_d = {wired_or_irq_enable_q, caf_q, 2'b00, bus_clock_output_select_q, era_q, lat_q, pgm_q};
         end else if (is_stat) begin
            rdata_d[EEC_SB_BUSY] = pgm_q && !tmr_done;
            rdata_d[EEC_SB_DONE] = done_q;
            rdata_d[EEC_SB_REFUSED] = refused_q;
         end else if (is_arr) begin
            // rom-like read only with the latch clear [RULE10] [RULE14]
            rdata_d = lat_q ? EEC_ERASED : arr_rdata;
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // whole register clears on reset [RULE20] [RULE8]
         {wired_or_irq_enable_q, caf_q, bus_clock_output_select_q, era_q, lat_q, pgm_q} <= '0;
         cap_q <= 1'b0;
         tgt_addr_q <= EEC_ZERO;
         tgt_data_q <= EEC_ZERO;
         done_q <= 1'b0;
         refused_q <= 1'b0;
         rdata_q <= EEC_CTRL_RESET;
      end else begin
         wired_or_irq_enable_q <= wired_or_irq_enable_d;
         caf_q <= caf_d;
         bus_clock_output_select_q <= bus_clock_output_select_d;
         era_q <= era_d;
         lat_q <= lat_d;
         pgm_q <= pgm_d;
         cap_q <= cap_d;
         tgt_addr_q <= tgt_addr_d;
         tgt_data_q <= tgt_data_d;
         done_q <= done_d;
         refused_q <= refused_d;
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign bus_rdata = rdata_q;
   assign pump_enable_out = (mode == EEC_MODE_PROG) || (mode == EEC_MODE_ERASING); // [RULE9]
   assign wired_or_irq_enable = wired_or_irq_enable_q;
   assign bus_clock_output_select = bus_clock_output_select_q;
   assign nvm_busy = pgm_q && !tmr_done; // [RULE21]
   assign nvm_done = done_q;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   latch_low_clear_a: assert property (!lat_q |-> !era_q && !pgm_q) // [RULE7]
      else $error("select or pump set with latch low");
   latch_read_ff_a: assert property (bus_rd && is_arr && lat_q |=> bus_rdata == 8'hff) // [RULE10]
      else $error("array read under latch not all ones");
   pump_after_cap_a: assert property ($rose(pgm_q) |-> cap_q && $past(cap_q)) // [RULE9]
      else $error("pump started without captured data");
   pump_fall_lat_a: assert property ($fell(pgm_q) |-> !lat_q) // [RULE9]
      else $error("pump cleared while latch stays set");
   erase_sel_frozen_a: assert property (cap_q && $past(cap_q) |-> $stable(era_q)) // [RULE6]
      else $error("erase select changed after capture");
   target_fixed_a: assert property (cap_q && $past(cap_q) |-> $stable(tgt_addr_q)) // [RULE15]
      else $error("target address changed within a sequence");
   stop_clears_a: assert property (stop_mode_enter |=> !lat_q && !pgm_q && !pump_enable_out) // [RULE19]
      else $error("stop entry left the array out of read mode");
   wired_or_irq_enable_mask_a: assert property (!wired_or_mask_option |=> !wired_or_irq_enable) // [RULE4]
      else $error("interrupt enable set without mask option");
   ctrl_reserved_a: assert property (bus_rd && is_ctrl |=> bus_rdata[5:4] == 2'b00) // [RULE20]
      else $error("reserved control bits read nonzero");
   protect_block_a: assert property (tmr_pulse && prot_hit |-> !arr_we ##1 refused_q) // [RULE18]
      else $error("protected byte was altered");
   erase_value_a: assert property (arr_we && era_q |-> arr_wdata == 8'hff) // [RULE12]
      else $error("erase did not write all ones");
   caf_follow_a: assert property (can_sleep_enter |=> caf_q) // [RULE5]
      else $error("sleep flag not set on sleep entry");

   erase_done_c: cover property (arr_we && era_q);
   prog_done_c: cover property (arr_we && !era_q);
   refused_c: cover property (tmr_pulse && prot_hit);
   other_addr_c: cover property (wr_arr && lat_q && cap_q && !cap_ok);
endmodule

/* inc/eec_pkg.sv */
// Functional notes
// [RULE1] a 256-byte byte-erasable array is mapped into the cpu address space
// [RULE2] only single-byte erase exists; no bulk or row erase
// [RULE3] erase, latch and pump bits decode into read, load, program, erase modes
// [RULE4] bit 7 enables wired-or interrupts; forced low without mask option
// [RULE5] bit 6 is set while the can module sleeps, cleared on wake
// [RULE6] bit 2 picks erase or program and freezes once an address is taken
// [RULE7] bit 1 lets address/data be taken; while low bits 2 and 0 stay low
// [RULE8] stop entry and every reset clear the latch bit
// [RULE9] bit 0 runs the pump; settable only after capture, cleared only with latch
// [RULE10] latch low reads like rom; latch high array reads give all ones
// [RULE11] software erase: latch+erase, write target, pump, wait, clear latch
// [RULE12] erase leaves all ones, program clears bits; erase data is ignored
// [RULE13] software program: latch, write data, pump, wait, clear latch
// [RULE14] other array accesses during an operation do not succeed
// [RULE15] after capture a write to another address has no effect
// [RULE16] software must erase a byte before programming it
// [RULE17] upper 224 bytes can be protected by the option byte protect bit
// [RULE18] protect bit low makes upper-region operations fail; low 32 never protected
// [RULE19] stop entry returns the array to read mode and stops the pump
// [RULE20] bits 5 and 4 read zero; sleep flag ignores writes; register resets zero
// [RULE21] a busy/done indication times the erase and program wait
package eec_pkg;
   // ************************************************************
   // address map
   // ************************************************************
   localparam logic [15:0] EEC_CTRL_ADDR = 16'h0007;
   localparam logic [15:0] EEC_STAT_ADDR = 16'h0020;
   localparam logic [15:0] EEC_ARR_BASE = 16'h0100;
   localparam int EEC_ARR_AW = 8;
   localparam int EEC_ARR_DEPTH = 256;
   localparam logic [7:0] EEC_UNPROT_TOP = 8'h1f; // highest never-protected offset
   // ************************************************************
   // control and status fields
   // ************************************************************
   localparam int EEC_CB_WIRED_OR_IRQ_ENABLE = 7;
   localparam int EEC_CB_CAF = 6;
   localparam int EEC_CB_BUS_CLOCK_OUTPUT_SELECT = 3;
   localparam int EEC_CB_ERA = 2;
   localparam int EEC_CB_LAT = 1;
   localparam int EEC_CB_PGM = 0;
   localparam logic [7:0] EEC_CTRL_RESET = 8'h00;
   localparam int EEC_SB_BUSY = 0;
   localparam int EEC_SB_DONE = 1;
   localparam int EEC_SB_REFUSED = 2;
   localparam logic [7:0] EEC_ERASED = 8'hff;
   localparam logic [7:0] EEC_ZERO = 8'h00;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int EEC_CLK_MHZ = 100;
   localparam int EEC_T_ERASE_US = 10000;
   localparam int EEC_T_PROG_US = 10000;
   localparam int EEC_ERASE_CYC = EEC_T_ERASE_US * EEC_CLK_MHZ;
   localparam int EEC_PROG_CYC = EEC_T_PROG_US * EEC_CLK_MHZ;
   localparam int EEC_TMR_W = 24;
   // ************************************************************
   // operating modes
   // ************************************************************
   typedef enum logic [2:0] {
      EEC_MODE_READ,
      EEC_MODE_LOAD,
      EEC_MODE_PROG,
      EEC_MODE_ERA_RDY,
      EEC_MODE_ERASING
   } eec_mode_t;
endpackage

/* core/eec_array.sv */
`timescale 1ns/100ps
module eec_array
   import eec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [EEC_ARR_AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic [EEC_ARR_AW-1:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem_q [EEC_ARR_DEPTH];

   // ************************************************************
   // one byte cell per entry, no reset: contents are nonvolatile
   // ************************************************************
   for (genvar i = 0; i < EEC_ARR_DEPTH; i++) begin : g_cell
      logic [7:0] cell_d;
      always_comb begin
         cell_d = mem_q[i];
         if (wr_en && (wr_addr == EEC_ARR_AW'(i))) begin
            cell_d = wr_data; // single byte only [RULE2]
         end
      end
      always_ff @(posedge sys_clk) begin
         mem_q[i] <= cell_d;
      end
   end

   // read by index
   assign rd_data = mem_q[rd_addr];
endmodule

/* core/eec_wait_timer.sv */
`timescale 1ns/100ps
module eec_wait_timer
   import eec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [EEC_TMR_W-1:0] len,
   output logic done,
   output logic done_pulse
);
   logic [EEC_TMR_W-1:0] cnt_q;
   logic [EEC_TMR_W-1:0] cnt_d;
   logic done_q;
   logic done_d;

   // ************************************************************
   // counts pump-on cycles, restarts whenever run drops
   // ************************************************************
   assign done_pulse = run && !done_q && (cnt_q == len - EEC_TMR_W'(1));
   assign done = done_q;

   // next count
   always_comb begin
      cnt_d = cnt_q;
      done_d = done_q;
      if (!run) begin
         cnt_d = '0;
         done_d = 1'b0;
      end else if (done_pulse) begin
         done_d = 1'b1; // [RULE21]
      end else if (!done_q) begin
         cnt_d = cnt_q + EEC_TMR_W'(1);
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end
endmodule

/* testbench/eec_cpu_model.sv */
`timescale 1ns/100ps
module eec_cpu_model
   import eec_pkg::*;
(
   input wire logic sys_clk,
   output logic [15:0] bus_addr,
   output logic [7:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   input wire logic [7:0] bus_rdata
);
   // ************************************************************
   // cpu side of the register bus
   // ************************************************************
   // bus idle at time zero
   initial begin
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end

   // one-cycle write, then data shows something else
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
   endtask

   // one-cycle read, data taken in the following cycle
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask
endmodule

/* testbench/test_eec_ctrl.sv */
`timescale 1ns/100ps
module test_eec_ctrl
   import eec_pkg::*;
;
   localparam int ERA_C = 20;
   localparam int PRG_C = 16;
   logic sys_clk, rst, bus_wr, bus_rd, stop_mode_enter, can_sleep_enter, can_wake;
   logic wired_or_mask_option, upper_region_protect, pump_enable_out, wired_or_irq_enable;
   logic bus_clock_output_select, nvm_busy, nvm_done;
   logic [15:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 85;
   int busy_n = 0;
   int m_mem[256];
   int m_wired_or_irq_enable, m_caf, m_bus_clock_output_select, m_era, m_lat, m_pgm, m_cap, m_ca, m_cd, m_stat;
   int offs[$];

   eec_ctrl #(.ERASE_CYCLES(ERA_C), .PROG_CYCLES(PRG_C)) eec_ctrl_inst (
      .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .stop_mode_enter(stop_mode_enter), .can_sleep_enter(can_sleep_enter),
      .can_wake(can_wake), .wired_or_mask_option(wired_or_mask_option),
      .upper_region_protect(upper_region_protect), .pump_enable_out(pump_enable_out),
      .wired_or_irq_enable(wired_or_irq_enable),
      .bus_clock_output_select(bus_clock_output_select),
      .nvm_busy(nvm_busy), .nvm_done(nvm_done));

   eec_cpu_model eec_cpu_model_inst (
      .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

   // ************************************************************
   // clock, watchdog, pump-on busy counter
   // ************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      wrap_up();
   end
   always @(posedge sys_clk) busy_n <= (pump_enable_out === 1'b1) ? busy_n + nvm_busy : 0;

   // ************************************************************
   // reference model and checking
   // ************************************************************
   task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic void mdl_wr(int a, int d);
      if (a == 7) begin
         if (((d >> 1) & 1) == 0) begin
            m_cap = 0;
            m_era = 0;
            m_pgm = 0;
            m_stat = 0;
         end else begin
            if (m_cap == 0) m_era = (d >> 2) & 1;
            // status shows busy from the edge that starts the pump
            if (m_cap && m_lat && !m_pgm && (d & 1)) m_stat = 1;
            if (m_cap && m_lat && (d & 1)) m_pgm = 1;
         end
         m_lat = (d >> 1) & 1;
         m_wired_or_irq_enable = (d >> 7) & 1 & int'(wired_or_mask_option);
         m_bus_clock_output_select = (d >> 3) & 1;
      end else if (a >= 256 && a < 512 && m_lat && !m_pgm && (!m_cap || a - 256 == m_ca)) begin
         m_cap = 1;
         m_ca = a - 256;
         m_cd = d;
      end
   endfunction
   function automatic int mdl_rd(int a);
      if (a == 7) return m_wired_or_irq_enable * 128 + m_caf * 64 + m_bus_clock_output_select * 8 + m_era * 4 + m_lat * 2 + m_pgm;
      if (a == EEC_STAT_ADDR) return m_stat;
      if (a >= 256 && a < 512) return m_lat ? 255 : m_mem[a - 256];
      return 0;
   endfunction
   task automatic bw(int a, int d);
      mdl_wr(a, d);
      eec_cpu_model_inst.wr(a[15:0], d[7:0]);
   endtask
   task automatic br(int a);
      logic [7:0] v;
      eec_cpu_model_inst.rd(a[15:0], v);
      chk("read", v, mdl_rd(a));
   endtask
   task automatic pulse(int k);
      @(posedge sys_clk);
      if (k == 0) can_sleep_enter <= 1'b1;
      else if (k == 1) can_wake <= 1'b1;
      else stop_mode_enter <= 1'b1;
      @(posedge sys_clk);
      can_sleep_enter <= 1'b0;
      can_wake <= 1'b0;
      stop_mode_enter <= 1'b0;
   endtask

   // full erase or program sequence on one offset, optional intruding write
   task automatic op(int o, int era, int d, int intr);
      int prot, n, k;
      n = era ? ERA_C : PRG_C;
      bw(7, era * 4 + 2);
      // protect level read only after the caller's edge update has landed
      prot = (o > 31) && (upper_region_protect == 1'b0);
      bw(256 + o, d);
      br(256 + o);
      if (intr >= 0) bw(256 + intr, 8'h3c);
      bw(7, (1 - era) * 4 + 2);
      bw(7, era * 4 + 3);
      br(7);
      if (!prot) chk("pump", pump_enable_out, 1);
      br(256 + o);
      bw(7, era * 4 + 2);
      br(7);
      br(EEC_STAT_ADDR);
      k = 0;
      while (nvm_done !== 1'b1 && k < 1000) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      chk("done", nvm_done, 1);
      chk("busy len", busy_n >= n && busy_n <= n + 1, 1);
      // wait over: done set, refused only for a protected target
      m_stat = prot ? 6 : 2;
      br(EEC_STAT_ADDR);
      if (!prot) m_mem[o] = era ? 255 : m_mem[o] & m_cd;
      bw(7, 0);
      br(256 + o);
      chk("done clr", nvm_done, 0);
      if (intr >= 0) br(256 + intr);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst = 1'b1;
      {stop_mode_enter, can_sleep_enter, can_wake} = 3'h0;
      wired_or_mask_option = 1'b1;
      upper_region_protect = 1'b1;
      {m_wired_or_irq_enable, m_caf, m_bus_clock_output_select, m_era, m_lat, m_pgm, m_cap, m_stat} = '0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      br(7);
      chk("pump", pump_enable_out, 0);
      $display("test reset done");
      bw(7, 8'hff);
      br(7);
      chk("wired_or_irq_enable", wired_or_irq_enable, 1);
      chk("bus_clock_output_select", bus_clock_output_select, 1);
      @(posedge sys_clk);
      wired_or_mask_option <= 1'b0;
      m_wired_or_irq_enable = 0;
      br(7);
      wired_or_mask_option <= 1'b1;
      bw(7, 8'h05);
      br(7);
      bw(7, 8'h02);
      bw(7, 8'h03);
      br(7);
      bw(7, 8'h00);
      $display("test control bits done");
      pulse(0);
      m_caf = 1;
      br(7);
      bw(7, 8'h00);
      br(7);
      pulse(1);
      m_caf = 0;
      br(7);
      $display("test sleep flag done");
      offs = '{0, 31, 32, 255};
      offs.push_back(1 + ($unsigned($random(seed)) % 30));
      foreach (offs[i]) begin
         op(offs[i], 1, $random(seed), i ? offs[0] : -1);
         op(offs[i], 0, i ? $random(seed) : 0, i ? offs[0] : -1);
      end
      $display("test erase program done");
      @(posedge sys_clk);
      upper_region_protect <= 1'b0;
      op(32, 1, 8'h11, -1);
      op(255, 1, 8'h22, -1);
      op(31, 1, 8'h33, -1);
      $display("test protect done");
      bw(7, 8'h06);
      bw(256, 8'h44);
      bw(7, 8'h07);
      pulse(2);
      {m_era, m_lat, m_pgm, m_cap, m_stat} = '0;
      br(7);
      chk("pump", pump_enable_out, 0);
      br(256);
      $display("test stop done");
      bw(16'h0030, 8'ha5);
      br(16'h0030);
      $display("test unmapped done");
      wrap_up();
   end
endmodule
